// file: shared/flash_ctrl_pkg.sv
// package: register map, field codes and timing for the flash window/cache control block
package flash_ctrl_pkg;
  // register byte offsets
  localparam logic [7:0] ctrl_off = 8'h00;
  localparam logic [7:0] status_off = 8'h04;
  localparam logic [7:0] nca_start_off = 8'h08;
  localparam logic [7:0] nca_end_off = 8'h0C;
  localparam logic [7:0] ncb_start_off = 8'h10;
  localparam logic [7:0] ncb_end_off = 8'h14;
  localparam logic [7:0] win_start_off = 8'h18;
  localparam logic [7:0] win_end_off = 8'h1C;
  localparam logic [7:0] op_addr_off = 8'h20;
  localparam logic [7:0] command_off = 8'h24;
  localparam logic [7:0] startup_area_ctrl_reg_off = 8'h28;
  localparam logic [7:0] flash_clock_off = 8'h2C;
  // ctrl fields
  localparam int ctrl_cache_en_bit = 0;
  localparam int ctrl_nca_en_bit = 1;
  localparam int ctrl_ncb_en_bit = 2;
  localparam int ctrl_dual_mode_bit = 3;
  // status fields
  localparam int st_busy_bit = 0;
  localparam int st_error_bit = 1;
  localparam int st_ready_bit = 2;
  localparam int st_swap_flag_bit = 3;
  localparam int st_cache_active_bit = 4;
  localparam int st_win_active_bit = 5;
  localparam int st_startup_region_bit = 6;
  // command codes, written to the command register
  localparam logic [3:0] cmd_program = 4'h1;
  localparam logic [3:0] cmd_erase = 4'h2;
  localparam logic [3:0] cmd_reset = 4'h3;
  localparam logic [3:0] cmd_swap_toggle = 4'h4;
  localparam logic [3:0] cmd_clear_ready = 4'h5;
  // startup area select codes
  localparam logic [1:0] select_follow_flag = 2'h0;
  localparam logic [1:0] select_region_zero = 2'h1;
  localparam logic [1:0] select_region_one = 2'h2;
  // reset values
  localparam logic [31:0] ctrl_reset = 32'h0000_0001;
  localparam logic [31:0] flash_clock_reset = 32'h0000_0020;
  localparam logic swap_flag_reset = 1'b1;
  // timing: program/erase and commit times
  localparam int clk_period_ns = 4;
  localparam int op_time_ns = 2000;
  localparam int commit_time_ns = 400;
  localparam int op_cycles = (op_time_ns + clk_period_ns - 1) / clk_period_ns;
  localparam int commit_cycles = (commit_time_ns + clk_period_ns - 1) / clk_period_ns;
  localparam logic [1:0] axi_okay = 2'h0;
  localparam logic [1:0] axi_slverr = 2'h2;
endpackage

// file: src/flash_seq_engine.sv
// sequencer engine: busy timing, access window check, error and done reporting
module flash_seq_engine #(
  parameter int addr_w = 24,
  parameter int op_len = flash_ctrl_pkg::op_cycles,
  parameter int commit_len = flash_ctrl_pkg::commit_cycles
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic start_op,
  input wire logic [addr_w-1:0] op_addr,
  input wire logic start_commit,
  input wire logic seq_reset,
  input wire logic win_active,
  input wire logic [addr_w-1:0] win_start,
  input wire logic [addr_w-1:0] win_end,
  output logic busy,
  output logic refused,
  output logic op_done,
  output logic commit_done
);
  typedef enum logic [2:0] {
    st_idle = 3'b001,
    st_op = 3'b010,
    st_commit = 3'b100
  } seq_state_t;

  seq_state_t state;
  logic [15:0] count;

  function automatic logic in_window(input logic [addr_w-1:0] a, input logic [addr_w-1:0] lo,
                                     input logic [addr_w-1:0] hi);
    in_window = (a >= lo) && (a <= hi);
  endfunction

  // ==========================================
  // sequencer state
  always_ff @(posedge aclk) begin
    refused <= 1'b0;
    op_done <= 1'b0;
    commit_done <= 1'b0;
    if (!aresetn) begin
      state <= st_idle;
      count <= 16'h0000;
    end else if (seq_reset) begin
      state <= st_idle;
      count <= 16'h0000;
    end else begin
      unique case (state)
        st_idle: begin
          if (start_commit) begin
            state <= st_commit;
            count <= 16'(commit_len - 1);
          end else if (start_op) begin
            if (win_active && !in_window(op_addr, win_start, win_end)) begin
              refused <= 1'b1;
            end else begin
              state <= st_op;
              count <= 16'(op_len - 1);
            end
          end
        end
        st_op: begin
          if (count == 16'h0000) begin
            state <= st_idle;
            op_done <= 1'b1;
          end else begin
            count <= count - 16'h0001;
          end
        end
        st_commit: begin
          if (count == 16'h0000) begin
            state <= st_idle;
            commit_done <= 1'b1;
          end else begin
            count <= count - 16'h0001;
          end
        end
      endcase
    end
  end

  assign busy = (state != st_idle);
endmodule

// file: src/flash_window_swap_cache_ctrl.sv
// top: register slave, non-cacheable ranges, access window, startup swap and select
// ==========================================
module flash_window_swap_cache_ctrl #(
  parameter int addr_w = 24
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [addr_w-1:0] fetch_addr,
  output logic fetch_bypass,
  output logic cache_enable,
  output logic flash_ready_irq,
  output logic startup_region
);
  logic [31:0] ctrl;
  logic [addr_w-1:0] nca_start, nca_end, ncb_start, ncb_end;
  logic [addr_w-1:0] win_start, win_end, op_addr;
  logic [31:0] flash_clock;
  logic [1:0] startup_area_select;
  logic swap_flag_boot, boot_pending;
  logic win_active, range_update, refused_err;
  logic [7:0] aw_addr;
  logic aw_held, w_held;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic wr_go;
  logic [3:0] cmd;
  logic start_op, start_commit, seq_reset, swap_go;
  logic busy, refused, op_done, commit_done;
  logic swap_pending;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] s);
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        old[i*8 +: 8] = d[i*8 +: 8];
      end
    end
    merge = old;
  endfunction

  function automatic logic hit(input logic [addr_w-1:0] a, input logic [addr_w-1:0] lo,
                               input logic [addr_w-1:0] hi);
    hit = (a >= lo) && (a <= hi);
  endfunction

  // ==========================================
  // write channel capture: address and data in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else if (wr_go) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
    end
  end

  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  assign wr_go = aw_held && w_held && !s_axi_bvalid;

  // ==========================================
  // write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= flash_ctrl_pkg::axi_okay;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (aw_addr[7:2] > flash_ctrl_pkg::flash_clock_off[7:2]) ? flash_ctrl_pkg::axi_slverr
                     : flash_ctrl_pkg::axi_okay;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ==========================================
  // configuration registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl <= flash_ctrl_pkg::ctrl_reset;
      nca_start <= '0;
      nca_end <= '0;
      ncb_start <= '0;
      ncb_end <= '0;
      op_addr <= '0;
      flash_clock <= flash_ctrl_pkg::flash_clock_reset;
    end else if (wr_go) begin
      unique case ({aw_addr[7:2], 2'b00})
        flash_ctrl_pkg::ctrl_off: ctrl <= merge(ctrl, w_data, w_strb);
        flash_ctrl_pkg::nca_start_off: nca_start <= addr_w'(merge(32'(nca_start), w_data, w_strb));
        flash_ctrl_pkg::nca_end_off: nca_end <= addr_w'(merge(32'(nca_end), w_data, w_strb));
        flash_ctrl_pkg::ncb_start_off: ncb_start <= addr_w'(merge(32'(ncb_start), w_data, w_strb));
        flash_ctrl_pkg::ncb_end_off: ncb_end <= addr_w'(merge(32'(ncb_end), w_data, w_strb));
        flash_ctrl_pkg::op_addr_off: op_addr <= addr_w'(merge(32'(op_addr), w_data, w_strb));
        flash_ctrl_pkg::flash_clock_off: flash_clock <= merge(flash_clock, w_data, w_strb);
        default: ;
      endcase
    end
  end

  // ==========================================
  // access window, one pair; commits go through the sequencer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      win_start <= '0;
      win_end <= '0;
    end else if (wr_go && !busy) begin
      if ({aw_addr[7:2], 2'b00} == flash_ctrl_pkg::win_start_off) begin
        win_start <= addr_w'(merge(32'(win_start), w_data, w_strb));
      end
      if ({aw_addr[7:2], 2'b00} == flash_ctrl_pkg::win_end_off) begin
        win_end <= addr_w'(merge(32'(win_end), w_data, w_strb));
      end
    end
  end

  assign win_active = (win_start != win_end);

  // ==========================================
  // command decode, one-cycle strobes
  assign cmd = w_data[3:0];
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      start_op <= 1'b0;
      start_commit <= 1'b0;
      seq_reset <= 1'b0;
      swap_go <= 1'b0;
      range_update <= 1'b0;
    end else begin
      start_op <= wr_go && !busy && ({aw_addr[7:2], 2'b00} == flash_ctrl_pkg::command_off)
                  && (cmd == flash_ctrl_pkg::cmd_program || cmd == flash_ctrl_pkg::cmd_erase);
      start_commit <= wr_go && !busy && ({aw_addr[7:2], 2'b00} == flash_ctrl_pkg::win_start_off
                      || {aw_addr[7:2], 2'b00} == flash_ctrl_pkg::win_end_off
                      || ({aw_addr[7:2], 2'b00} == flash_ctrl_pkg::command_off
                          && cmd == flash_ctrl_pkg::cmd_swap_toggle));
      swap_go <= wr_go && !busy && ({aw_addr[7:2], 2'b00} == flash_ctrl_pkg::command_off)
                 && cmd == flash_ctrl_pkg::cmd_swap_toggle;
      seq_reset <= wr_go && ({aw_addr[7:2], 2'b00} == flash_ctrl_pkg::command_off)
                   && cmd == flash_ctrl_pkg::cmd_reset;
      range_update <= wr_go && aw_addr[7:2] >= flash_ctrl_pkg::nca_start_off[7:2]
                      && aw_addr[7:2] <= flash_ctrl_pkg::ncb_end_off[7:2];
    end
  end

  flash_seq_engine #(.addr_w(addr_w)) engine (
    .aclk(aclk),
    .aresetn(aresetn),
    .start_op(start_op),
    .op_addr(op_addr),
    .start_commit(start_commit),
    .seq_reset(seq_reset),
    .win_active(win_active),
    .win_start(win_start),
    .win_end(win_end),
    .busy(busy),
    .refused(refused),
    .op_done(op_done),
    .commit_done(commit_done)
  );

  // ==========================================
  // persistent swap flag; survives reset, boot copy latched after release
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      swap_pending <= 1'b0;
    end else if (seq_reset) begin
      swap_pending <= 1'b0;
    end else if (swap_go) begin
      swap_pending <= 1'b1;
    end else if (commit_done) begin
      swap_pending <= 1'b0;
    end
  end

  // flag models nonvolatile storage, so bus reset leaves it alone
  logic swap_flag = flash_ctrl_pkg::swap_flag_reset;
  always_ff @(posedge aclk) begin
    if (aresetn && commit_done && swap_pending) begin
      swap_flag <= !swap_flag;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      boot_pending <= 1'b1;
      swap_flag_boot <= flash_ctrl_pkg::swap_flag_reset;
    end else if (boot_pending) begin
      boot_pending <= 1'b0;
      swap_flag_boot <= swap_flag;
    end
  end

  // ==========================================
  // startup area select
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      startup_area_select <= flash_ctrl_pkg::select_follow_flag;
    end else if (wr_go && ({aw_addr[7:2], 2'b00} == flash_ctrl_pkg::startup_area_ctrl_reg_off)
                 && !ctrl[flash_ctrl_pkg::ctrl_dual_mode_bit] && w_strb[0]
                 && w_data[1:0] != 2'h3) begin
      startup_area_select <= w_data[1:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      startup_region <= 1'b0;
    end else begin
      // three-way select, flag 0 means swapped
      unique case (startup_area_select)
        flash_ctrl_pkg::select_region_zero: startup_region <= 1'b0;
        flash_ctrl_pkg::select_region_one: startup_region <= 1'b1;
        default: startup_region <= !swap_flag_boot;
      endcase
    end
  end

  // ==========================================
  // ready interrupt and error, set wins over clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flash_ready_irq <= 1'b0;
    end else if (commit_done || op_done) begin
      flash_ready_irq <= 1'b1;
    end else if (wr_go && ({aw_addr[7:2], 2'b00} == flash_ctrl_pkg::command_off)
                 && cmd == flash_ctrl_pkg::cmd_clear_ready) begin
      flash_ready_irq <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      refused_err <= 1'b0;
    end else if (refused) begin
      refused_err <= 1'b1;
    end else if (start_op || seq_reset) begin
      refused_err <= 1'b0;
    end
  end

  // ==========================================
  // cache outputs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cache_enable <= 1'b0;
      fetch_bypass <= 1'b0;
    end else begin
      cache_enable <= ctrl[flash_ctrl_pkg::ctrl_cache_en_bit] && !range_update
                      && !(wr_go && aw_addr[7:2] >= flash_ctrl_pkg::nca_start_off[7:2]
                           && aw_addr[7:2] <= flash_ctrl_pkg::ncb_end_off[7:2]);
      fetch_bypass <= (ctrl[flash_ctrl_pkg::ctrl_nca_en_bit] && hit(fetch_addr, nca_start, nca_end))
                      || (ctrl[flash_ctrl_pkg::ctrl_ncb_en_bit] && hit(fetch_addr, ncb_start, ncb_end));
    end
  end

  // ==========================================
  // read channel, one cycle after address
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= flash_ctrl_pkg::axi_okay;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= flash_ctrl_pkg::axi_okay;
      s_axi_rdata <= 32'h0000_0000;
      unique case ({s_axi_araddr[7:2], 2'b00})
        flash_ctrl_pkg::ctrl_off: s_axi_rdata <= ctrl;
        flash_ctrl_pkg::status_off: begin
          s_axi_rdata[flash_ctrl_pkg::st_busy_bit] <= busy;
          s_axi_rdata[flash_ctrl_pkg::st_error_bit] <= refused_err;
          s_axi_rdata[flash_ctrl_pkg::st_ready_bit] <= flash_ready_irq;
          s_axi_rdata[flash_ctrl_pkg::st_swap_flag_bit] <= swap_flag;
          s_axi_rdata[flash_ctrl_pkg::st_cache_active_bit] <= cache_enable;
          s_axi_rdata[flash_ctrl_pkg::st_win_active_bit] <= win_active;
          s_axi_rdata[flash_ctrl_pkg::st_startup_region_bit] <= startup_region;
        end
        flash_ctrl_pkg::nca_start_off: s_axi_rdata <= 32'(nca_start);
        flash_ctrl_pkg::nca_end_off: s_axi_rdata <= 32'(nca_end);
        flash_ctrl_pkg::ncb_start_off: s_axi_rdata <= 32'(ncb_start);
        flash_ctrl_pkg::ncb_end_off: s_axi_rdata <= 32'(ncb_end);
        flash_ctrl_pkg::win_start_off: s_axi_rdata <= 32'(win_start);
        flash_ctrl_pkg::win_end_off: s_axi_rdata <= 32'(win_end);
        flash_ctrl_pkg::op_addr_off: s_axi_rdata <= 32'(op_addr);
        flash_ctrl_pkg::command_off: s_axi_rdata <= 32'h0000_0000;
        flash_ctrl_pkg::startup_area_ctrl_reg_off: begin
          if (ctrl[flash_ctrl_pkg::ctrl_dual_mode_bit]) begin
            s_axi_rresp <= flash_ctrl_pkg::axi_slverr;
          end else begin
            s_axi_rdata <= {30'h0000_0000, startup_area_select};
          end
        end
        flash_ctrl_pkg::flash_clock_off: s_axi_rdata <= flash_clock;
        default: s_axi_rresp <= flash_ctrl_pkg::axi_slverr;
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule

// file: verification/flash_ctrl_monitor.sv
// checker: bus handshakes, reset and flag timing of the flash control block
module flash_ctrl_monitor (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic cache_enable,
  input wire logic flash_ready_irq
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic range_aw;
  logic both_hs;
  assign range_aw = s_axi_awvalid && s_axi_awready && (s_axi_awaddr inside {flash_ctrl_pkg::nca_start_off,
                    flash_ctrl_pkg::nca_end_off, flash_ctrl_pkg::ncb_start_off, flash_ctrl_pkg::ncb_end_off});
  assign both_hs = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  // ==========================================
  // assertions
  chk_b_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped early");
  chk_r_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  chk_write_answer: assert property (both_hs |-> ##[1:2] s_axi_bvalid)
    else $error("write answer late");
  chk_b_blocks: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  chk_r_blocks: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while data pending");
  chk_cache_pause: assert property (range_aw |-> ##[0:3] !cache_enable)
    else $error("cache not paused on range write");
  // a clear only lands with the write that raises bvalid in the same edge
  chk_irq_sticky: assert property (flash_ready_irq |=> flash_ready_irq || s_axi_bvalid)
    else $error("ready flag lost without clear");
  chk_reset_quiet: assert property (disable iff (1'b0) !aresetn |=> !s_axi_bvalid && !s_axi_rvalid && !flash_ready_irq)
    else $error("outputs active after reset");
  cover property ($rose(flash_ready_irq));
  cover property (range_aw);
  cover property (s_axi_rvalid && s_axi_rready);
endmodule
bind flash_window_swap_cache_ctrl flash_ctrl_monitor mon (.*);

// file: verification/flash_window_swap_cache_ctrl_tb_top.sv
// testbench: register-level tests of the flash window, swap and cache control block
module flash_window_swap_cache_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic fetch_bypass, cache_enable, flash_ready_irq, startup_region;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, q;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [23:0] fetch_addr;
  int errors, compares, a, flag;
  int rng[4];
  localparam logic [7:0] st = flash_ctrl_pkg::status_off;
  localparam logic [7:0] cmd = flash_ctrl_pkg::command_off;
  localparam logic [7:0] sel = flash_ctrl_pkg::startup_area_ctrl_reg_off;
  localparam logic [31:0] busy_m = 32'h1 << flash_ctrl_pkg::st_busy_bit;
  localparam logic [31:0] err_m = 32'h1 << flash_ctrl_pkg::st_error_bit;
  localparam logic [31:0] flag_m = 32'h1 << flash_ctrl_pkg::st_swap_flag_bit;
  localparam logic [31:0] win_m = 32'h1 << flash_ctrl_pkg::st_win_active_bit;
  flash_window_swap_cache_ctrl dut (.*);
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic stop_test();
    $display("counts: %0d compares, %0d errors", compares, errors);
    if (errors == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // ==========================================
  // bus access: each channel held until its own handshake
  task automatic acc(input bit rd, input logic [7:0] ad, input logic [31:0] d);
    bit pa, pw, h;
    int n;
    @(posedge aclk);
    pa = 1;
    pw = !rd;
    h = 0;
    n = 0;
    if (rd) begin
      s_axi_araddr <= ad;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
    end else begin
      s_axi_awaddr <= ad;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
    end
    while ((pa || pw) && n++ < 50) begin
      @(negedge aclk);
      pa = pa && !(rd ? s_axi_arready : s_axi_awready);
      pw = pw && !s_axi_wready;
      @(posedge aclk);
      if (!pa && rd) s_axi_arvalid <= 1'b0;
      if (!pa && !rd) s_axi_awvalid <= 1'b0;
      if (!pw) s_axi_wvalid <= 1'b0;
    end
    while (!h && n++ < 100) begin
      @(negedge aclk);
      h = rd ? s_axi_rvalid : s_axi_bvalid;
      q = s_axi_rdata;
      r = rd ? s_axi_rresp : s_axi_bresp;
      @(posedge aclk);
    end
    if (pa || pw || !h) errors++;
    s_axi_rready <= 1'b0;
    s_axi_bready <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    acc(1'b0, ad, d);
  endtask
  task automatic rdc(input logic [7:0] ad, input logic [31:0] m, input logic [31:0] e, input string nm);
    acc(1'b1, ad, 32'h0);
    check(nm, e, q & m);
  endtask
  task automatic settle();
    repeat (3) @(posedge aclk);
    #1;
  endtask
  task automatic wait_idle();
    int n;
    n = 0;
    q = busy_m;
    while ((q & busy_m) !== 32'h0 && n++ < 400) acc(1'b1, st, 32'h0);
    if ((q & busy_m) !== 32'h0) errors++;
  endtask
  task automatic clear_irq();
    wr(cmd, {28'h0, flash_ctrl_pkg::cmd_clear_ready});
    settle();
    check("irq clear", 1'b0, flash_ready_irq);
  endtask
  task automatic win(input logic [31:0] s, input logic [31:0] e);
    wr(flash_ctrl_pkg::win_start_off, s);
    wait_idle();
    wr(flash_ctrl_pkg::win_end_off, e);
    wait_idle();
    settle();
    check("win irq", 1'b1, flash_ready_irq);
    rdc(flash_ctrl_pkg::win_start_off, 32'hFFFFFF, s, "win start");
    rdc(flash_ctrl_pkg::win_end_off, 32'hFFFFFF, e, "win end");
    rdc(st, win_m, (s != e) ? win_m : 32'h0, "win active");
    clear_irq();
  endtask
  task automatic op(input logic [31:0] ad, input logic [3:0] c, input bit refused);
    wr(flash_ctrl_pkg::op_addr_off, ad);
    wr(cmd, {28'h0, c});
    rdc(st, refused ? busy_m | err_m : busy_m, refused ? err_m : busy_m, "op start");
    wait_idle();
    settle();
    check("op irq", !refused, flash_ready_irq);
    if (!refused) clear_irq();
  endtask
  function automatic bit byp(int f);
    return (f >= rng[0] && f <= rng[1]) || (f >= rng[2] && f <= rng[3]);
  endfunction
  initial begin
    #200000;
    errors++;
    stop_test();
  end
  initial begin
    errors = 0;
    compares = 0;
    flag = 1;
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, fetch_addr} = '0;
    s_axi_wstrb = 4'hF;
    void'($urandom(32'hAF2C));
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    rdc(flash_ctrl_pkg::ctrl_off, 32'hFFFFFFFF, flash_ctrl_pkg::ctrl_reset, "ctrl");
    rdc(flash_ctrl_pkg::flash_clock_off, 32'hFFFFFFFF, flash_ctrl_pkg::flash_clock_reset, "clock");
    rdc(st, busy_m | flag_m, flag_m, "status");
    rdc(sel, 32'h3, flash_ctrl_pkg::select_follow_flag, "select");
    rdc(cmd, 32'hFFFFFFFF, 32'h0, "command");
    rdc(8'h30, 32'h0, 32'h0, "unmapped");
    check("unmapped resp", flash_ctrl_pkg::axi_slverr, r);
    check("region", 1'b0, startup_region);
    $display("test reset values done");
    rng[0] = $urandom_range(32'h1FFF, 32'h1000);
    rng[1] = rng[0] + 32'h800;
    rng[2] = $urandom_range(32'h10FFF, 32'h10000);
    rng[3] = rng[2] + 32'h800;
    for (int i = 0; i < 4; i++) wr(flash_ctrl_pkg::nca_start_off + 8'(4 * i), rng[i]);
    for (int i = 0; i < 4; i++) rdc(flash_ctrl_pkg::nca_start_off + 8'(4 * i), 32'hFFFFFF, rng[i], "range");
    // cache must be running again once the range writes are over
    rdc(st, 32'h1 << flash_ctrl_pkg::st_cache_active_bit, 32'h1 << flash_ctrl_pkg::st_cache_active_bit, "cache");
    wr(flash_ctrl_pkg::ctrl_off, 32'h7);
    for (int i = 0; i < 8; i++) begin
      a = (i < 2) ? rng[2 * i] + 5 : $urandom_range(32'h12000);
      @(posedge aclk);
      fetch_addr <= a[23:0];
      settle();
      check("bypass", byp(a), fetch_bypass);
    end
    $display("test ranges done");
    // stimulus keeps start at or below end and the clock unchanged
    win(32'h100, 32'h1FF);
    op(32'h300, flash_ctrl_pkg::cmd_program, 1'b1);
    op(32'h150, flash_ctrl_pkg::cmd_erase, 1'b0);
    win(32'h400, 32'h4FF);
    op(32'h150, flash_ctrl_pkg::cmd_program, 1'b1);
    op(32'h450, flash_ctrl_pkg::cmd_erase, 1'b0);
    win(32'h200, 32'h200);
    op(32'h300, flash_ctrl_pkg::cmd_program, 1'b0);
    wr(cmd, {28'h0, flash_ctrl_pkg::cmd_program});
    wr(cmd, {28'h0, flash_ctrl_pkg::cmd_reset});
    rdc(st, busy_m, 32'h0, "seq reset");
    wr(cmd, {28'h0, flash_ctrl_pkg::cmd_clear_ready});
    $display("test window done");
    wr(cmd, {28'h0, flash_ctrl_pkg::cmd_swap_toggle});
    flag = 0;
    wait_idle();
    settle();
    check("swap irq", 1'b1, flash_ready_irq);
    rdc(st, flag_m, flag ? flag_m : 32'h0, "flag");
    clear_irq();
    for (int s = 1; s < 4; s++) begin
      wr(sel, s % 3);
      settle();
      check("region", s == 2, startup_region);
      rdc(sel, 32'h3, s % 3, "select");
    end
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    settle();
    check("region boot", !flag, startup_region);
    rdc(sel, 32'h3, flash_ctrl_pkg::select_follow_flag, "select");
    wr(flash_ctrl_pkg::ctrl_off, 32'h9);
    wr(sel, {30'h0, flash_ctrl_pkg::select_region_one});
    rdc(sel, 32'h0, 32'h0, "dual select");
    check("dual resp", flash_ctrl_pkg::axi_slverr, r);
    wr(flash_ctrl_pkg::ctrl_off, 32'h1);
    rdc(sel, 32'h3, flash_ctrl_pkg::select_follow_flag, "select");
    $display("test swap and select done");
    stop_test();
  end
endmodule
